// ===== axil_slave.sv
// AXI4-Lite slave front end: one write and one read in flight at most
`timescale 1ns/1ps
module axil_slave
  import irq_flag_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  reg_if.bus                     rif
);
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    rd_state_e         rd_state;
    logic [ADDR_W-1:0] ar_addr;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } axi_s;

  axi_s st_q;
  axi_s st_d;

  // the write fires once both halves are held and the old response is gone
  assign rif.wr_en   = st_q.aw_held & st_q.w_held & ~st_q.bvalid;
  assign rif.wr_addr = st_q.aw_addr;
  assign rif.wr_data = st_q.wdata;
  assign rif.wr_strb = st_q.wstrb;
  assign rif.rd_addr = st_q.ar_addr;

  always_comb begin
    st_d = st_q;
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_held = 1'b1;
      st_d.wdata  = s_axi_wdata;
      st_d.wstrb  = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (rif.wr_en) begin
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = rif.wr_err ? RESP_DECERR : RESP_OKAY;
    end
    // no new address or data is taken until the response has gone
    st_d.awready = ~st_d.aw_held & ~st_d.bvalid & ~rif.wr_en;
    st_d.wready  = ~st_d.w_held & ~st_d.bvalid & ~rif.wr_en;
    case (st_q.rd_state)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          st_d.ar_addr  = s_axi_araddr;
          st_d.rd_state = RD_FETCH;
        end
      end
      RD_FETCH: begin
        st_d.rdata    = rif.rd_data;
        st_d.rresp    = rif.rd_err ? RESP_DECERR : RESP_OKAY;
        st_d.rd_state = RD_RESP;
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          st_d.rd_state = RD_IDLE;
        end
      end
      default: begin
        st_d.rd_state = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.awready  <= 1'b1;
      st_q.wready   <= 1'b1;
      st_q.rd_state <= RD_IDLE;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = (st_q.rd_state == RD_IDLE);
  assign s_axi_rvalid  = (st_q.rd_state == RD_RESP);
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
endmodule : axil_slave

// ===== flag_cell.sv
// one sticky flag bit: hardware set beats hardware clear beats software write
`timescale 1ns/1ps
module flag_cell (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic hw_set,
  input  wire logic hw_clr,
  input  wire logic sw_wr,
  input  wire logic sw_val,
  output logic      q
);
  typedef struct packed {
    logic flag;
  } cell_s;

  cell_s cell_q;
  cell_s cell_d;

  always_comb begin
    cell_d = cell_q;
    // set wins so an event in the clearing cycle is never lost
    if (hw_set) begin
      cell_d.flag = 1'b1;
    end else if (hw_clr) begin
      cell_d.flag = 1'b0;
    end else if (sw_wr) begin
      cell_d.flag = sw_val;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cell_q <= '0;
    end else if (ce) begin
      cell_q <= cell_d;
    end
  end

  assign q = cell_q.flag;
endmodule : flag_cell

// ===== irq_flag_pkg.sv
// constants, register map and types shared by the peripheral flag bank
package irq_flag_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NFLAG  = 14;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [ADDR_W-1:0] FLAGS_A_OFF    = 8'h00;
  localparam logic [ADDR_W-1:0] FLAGS_C_OFF    = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFF   = 8'h0C;

  // flag vector index: 7..0 are register a bits 7..0, 13..8 are register c bits 5..0
  localparam int PP_BIT   = 7;
  localparam int ADC_BIT  = 6;
  localparam int RXA_BIT  = 5;
  localparam int TXA_BIT  = 4;
  localparam int SSP_BIT  = 3;
  localparam int CCPA_BIT = 2;
  localparam int TMRB_BIT = 1;
  localparam int TMRA_BIT = 0;
  localparam int RXB_BIT  = 13;
  localparam int TXB_BIT  = 12;
  localparam int TMRD_BIT = 11;
  localparam int CCPE_BIT = 10;
  localparam int CCPD_BIT = 9;
  localparam int CCPC_BIT = 8;
  localparam int C_LSB    = 8;
  localparam int C_W      = 6;

  // receive and transmit flags are read-only to software
  localparam logic [NFLAG-1:0] WRITABLE_MASK = 14'h0FCF;
  localparam logic [NFLAG-1:0] MASK_RESET    = 14'h0000;

  localparam logic [1:0] CCP_OFF     = 2'h0;
  localparam logic [1:0] CCP_CAPTURE = 2'h1;
  localparam logic [1:0] CCP_COMPARE = 2'h2;
  localparam logic [1:0] CCP_PWM     = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    RD_IDLE  = 3'h1,
    RD_FETCH = 3'h2,
    RD_RESP  = 3'h4
  } rd_state_e;

endpackage : irq_flag_pkg

// ===== periph_events.sv
// model of the on-chip peripherals that raise request events
`timescale 1ns/1ps
module periph_events (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        fire,
  input  wire logic [4:0]  sel,
  output logic      [18:0] ev
);
  //////////////////////////////////////////////////////////////////////////////
  // each unit reports an event as a one-cycle strobe and then drops it, so a
  // flag that merely follows its input would lose the event
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ev <= 19'h00000;
    end else begin
      ev <= fire ? (19'h00001 << sel) : 19'h00000;
    end
  end
endmodule : periph_events

// ===== periph_flag_bank.sv
// peripheral interrupt request flag bank with AXI4-Lite access and a masked irq
//
// How it works
// [R1] parallel port flag sets on any host read or write and stays set; the code clears it when software writes zero to register a bit 7.
// [R2] parallel port flag only works in single-chip mode with external bus idle.
// [R3] converter flag sets when a conversion ends, held until software writes zero.
// [R4] serial a receive flag is read-only, set on a character, cleared by buffer read.
// [R5] serial a transmit flag is read-only, set when empty, cleared by buffer write.
// [R6] sync serial flag sets when a transfer completes, held until software clears.
// [R7] capture mode: capture/compare a flag sets on each capture of timer a.
// [R8] compare mode sets the flag on a match; pwm mode never sets it.
// [R9] timer b flag sets when its count equals its period, held until cleared.
// [R10] timer a flag sets on overflow, held until software writes zero.
// [R11] register c bits seven and six read zero; all flags reset to zero.
// [R12] flags set on their condition whatever any interrupt enable says.
// [R13] software should clear a flag before enabling and after servicing it.
`timescale 1ns/1ps
module periph_flag_bank
  import irq_flag_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic                   ce,
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [DATA_W-1:0]      s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [DATA_W-1:0]           s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   single_chip_mode,
  input  wire logic                   ext_bus_active,
  input  wire logic                   psp_access,
  input  wire logic                   adc_done,
  input  wire logic                   rx_a_loaded,
  input  wire logic                   rx_a_read,
  input  wire logic                   tx_a_empty,
  input  wire logic                   tx_a_written,
  input  wire logic                   sync_serial_done,
  input  wire logic [1:0]             capcomp_a_mode,
  input  wire logic                   capture_a,
  input  wire logic                   compare_a,
  input  wire logic                   timer_b_match,
  input  wire logic                   timer_a_overflow,
  input  wire logic                   rx_b_loaded,
  input  wire logic                   rx_b_read,
  input  wire logic                   tx_b_empty,
  input  wire logic                   tx_b_written,
  input  wire logic                   timer_d_event,
  input  wire logic [2:0]             capcomp_cde_event,
  output logic [7:0]                  peripheral_request_flags_a,
  output logic [7:0]                  peripheral_request_flags_c,
  output logic                        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_q;
  logic rst_n;

  // assert at once, release two clean edges later
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus front end

  reg_if rif ();

  axil_slave u_bus (
    .clk           (ref_clk),
    .rst_n         (rst_n),
    .ce            (ce),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .rif           (rif.bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write decode

  logic [NFLAG-1:0] byte_en;
  logic [NFLAG-1:0] wval;
  logic [NFLAG-1:0] wval_flags;
  logic [NFLAG-1:0] wr_flags_v;
  logic             wr_a;
  logic             wr_c;
  logic             wr_stat;
  logic             wr_mask;
  logic             psp_allowed;

  assign byte_en    = {{C_W{rif.wr_strb[1]}}, {C_LSB{rif.wr_strb[0]}}};
  assign wval       = rif.wr_data[NFLAG-1:0];
  assign wval_flags = {rif.wr_data[C_W-1:0], rif.wr_data[C_LSB-1:0]};
  assign wr_a       = rif.wr_en & (rif.wr_addr == FLAGS_A_OFF) & rif.wr_strb[0];
  assign wr_c       = rif.wr_en & (rif.wr_addr == FLAGS_C_OFF) & rif.wr_strb[0];
  assign wr_stat    = rif.wr_en & (rif.wr_addr == IRQ_STATUS_OFF);
  assign wr_mask    = rif.wr_en & (rif.wr_addr == IRQ_MASK_OFF);
  // read-only bits ignore software writes
  assign wr_flags_v = {{C_W{wr_c}}, {C_LSB{wr_a}}} & WRITABLE_MASK;
  assign rif.wr_err = ~(rif.wr_addr == FLAGS_A_OFF || rif.wr_addr == FLAGS_C_OFF ||
                        rif.wr_addr == IRQ_STATUS_OFF || rif.wr_addr == IRQ_MASK_OFF);

  ////////////////////////////////////////////////////////////////////////////
  // flag conditions

  logic [NFLAG-1:0] set_v;
  logic [NFLAG-1:0] hwclr_v;
  logic [NFLAG-1:0] flags_v;
  logic [NFLAG-1:0] status_v;

  // [R2] single-chip gating
  assign psp_allowed = single_chip_mode & ~ext_bus_active;

  // conditions reach the flags with no enable in the path
  always_comb begin
    set_v   = '0;
    hwclr_v = '0;
    // [R1] parallel port access
    set_v[PP_BIT]   = psp_access & psp_allowed;
    // [R3] conversion done
    set_v[ADC_BIT]  = adc_done;
    // [R4] receive buffer full
    set_v[RXA_BIT]  = rx_a_loaded;
    hwclr_v[RXA_BIT] = rx_a_read;
    // [R5] transmit buffer empty
    set_v[TXA_BIT]  = tx_a_empty;
    hwclr_v[TXA_BIT] = tx_a_written;
    // [R6] sync serial done
    set_v[SSP_BIT]  = sync_serial_done;
    // [R7] capture event
    // [R8] compare match, pwm silent
    set_v[CCPA_BIT] = ((capcomp_a_mode == CCP_CAPTURE) & capture_a) |
                      ((capcomp_a_mode == CCP_COMPARE) & compare_a);
    // [R9] period match
    set_v[TMRB_BIT] = timer_b_match;
    // [R10] counter overflow
    set_v[TMRA_BIT] = timer_a_overflow;
    set_v[RXB_BIT]  = rx_b_loaded;
    hwclr_v[RXB_BIT] = rx_b_read;
    set_v[TXB_BIT]  = tx_b_empty;
    hwclr_v[TXB_BIT] = tx_b_written;
    set_v[TMRD_BIT] = timer_d_event;
    set_v[CCPE_BIT] = capcomp_cde_event[2];
    set_v[CCPD_BIT] = capcomp_cde_event[1];
    set_v[CCPC_BIT] = capcomp_cde_event[0];
  end

  // [R12] flags and status ignore the mask
  for (genvar i = 0; i < NFLAG; i++) begin : g_flag
    flag_cell u_flag (
      .clk    (ref_clk),
      .rst_n  (rst_n),
      .ce     (ce),
      .hw_set (set_v[i]),
      .hw_clr (hwclr_v[i]),
      .sw_wr  (wr_flags_v[i]),
      .sw_val (wval_flags[i]),
      .q      (flags_v[i])
    );
    // status is write-one-to-clear, a fresh event still wins
    flag_cell u_stat (
      .clk    (ref_clk),
      .rst_n  (rst_n),
      .ce     (ce),
      .hw_set (set_v[i]),
      .hw_clr (wr_stat & byte_en[i] & wval[i]),
      .sw_wr  (1'b0),
      .sw_val (1'b0),
      .q      (status_v[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask and interrupt

  typedef struct packed {
    logic [NFLAG-1:0] mask;
    logic             irq;
  } bank_s;

  bank_s st_q;
  bank_s st_d;

  always_comb begin
    st_d = st_q;
    if (wr_mask) begin
      st_d.mask = (st_q.mask & ~byte_en) | (wval & byte_en);
    end
    st_d.irq = |(status_v & st_q.mask);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= '0;
      st_q.mask <= MASK_RESET;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rif.rd_data = '0;
    rif.rd_err  = 1'b0;
    case (rif.rd_addr)
      FLAGS_A_OFF:    rif.rd_data[C_LSB-1:0] = flags_v[C_LSB-1:0];
      // [R11] upper bits of register c read zero
      FLAGS_C_OFF:    rif.rd_data[C_W-1:0]   = flags_v[NFLAG-1:C_LSB];
      IRQ_STATUS_OFF: rif.rd_data[NFLAG-1:0] = status_v;
      IRQ_MASK_OFF:   rif.rd_data[NFLAG-1:0] = st_q.mask;
      default:        rif.rd_err = 1'b1;
    endcase
  end

  assign peripheral_request_flags_a = flags_v[C_LSB-1:0];
  assign peripheral_request_flags_c = {2'b00, flags_v[NFLAG-1:C_LSB]};
  assign irq                        = st_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  psp_set_a: assert property ( // [R1]
    ce && psp_access && single_chip_mode && !ext_bus_active
      |=> peripheral_request_flags_a[PP_BIT])
    else $error("parallel port flag missed an access");

  psp_gate_a: assert property ( // [R2]
    ce && !flags_v[PP_BIT] && !psp_allowed && !(wr_flags_v[PP_BIT] && wval_flags[PP_BIT])
      |=> !flags_v[PP_BIT])
    else $error("parallel port flag set outside single-chip mode");

  adc_hold_a: assert property ( // [R3]
    ce && flags_v[ADC_BIT] && !(wr_flags_v[ADC_BIT] && !wval_flags[ADC_BIT])
      |=> flags_v[ADC_BIT])
    else $error("converter flag dropped without a zero write");

  rx_set_a: assert property ( // [R4]
    ce && rx_a_loaded |=> flags_v[RXA_BIT])
    else $error("receive flag missed a character");

  rx_follow_a: assert property ( // [R4]
    ce && rx_a_read && !rx_a_loaded |=> !peripheral_request_flags_a[RXA_BIT])
    else $error("receive flag not cleared by buffer read");

  tx_set_a: assert property ( // [R5]
    ce && tx_a_empty |=> flags_v[TXA_BIT])
    else $error("transmit flag missed an empty buffer");

  tx_clear_a: assert property ( // [R5]
    ce && tx_a_written && !tx_a_empty |=> !flags_v[TXA_BIT])
    else $error("transmit flag not cleared by buffer write");

  ssp_set_a: assert property ( // [R6]
    ce && sync_serial_done |=> flags_v[SSP_BIT])
    else $error("sync serial flag missed a completion");

  capture_set_a: assert property ( // [R7]
    ce && capcomp_a_mode == CCP_CAPTURE && capture_a |=> flags_v[CCPA_BIT])
    else $error("capture did not set the flag");

  pwm_quiet_a: assert property ( // [R8]
    ce && capcomp_a_mode == CCP_PWM && !flags_v[CCPA_BIT]
      && !(wr_flags_v[CCPA_BIT] && wval_flags[CCPA_BIT]) |=> !flags_v[CCPA_BIT])
    else $error("capture/compare flag set in pwm mode");

  tmrb_set_a: assert property ( // [R9]
    ce && timer_b_match |=> flags_v[TMRB_BIT])
    else $error("period match did not set the flag");

  tmra_set_a: assert property ( // [R10]
    ce && timer_a_overflow |=> flags_v[TMRA_BIT])
    else $error("overflow did not set the flag");

  unimpl_zero_a: assert property ( // [R11]
    s_axi_rvalid && rif.rd_addr == FLAGS_C_OFF |-> s_axi_rdata[DATA_W-1:C_W] == '0)
    else $error("register c upper bits not zero");

  unmasked_set_a: assert property ( // [R12]
    ce && adc_done && st_q.mask == '0 |=> flags_v[ADC_BIT] && status_v[ADC_BIT] && !irq)
    else $error("flag depends on the mask");

  // irq is one register behind the status and mask it is built from
  irq_level_a: assert property (
    ce && (status_v & st_q.mask) != '0 |=> irq)
    else $error("irq not raised for an unmasked status bit");

  irq_drop_a: assert property (
    ce && (status_v & st_q.mask) == '0 |=> !irq)
    else $error("irq raised with no unmasked status bit");

  // a low enable must stall every flag, status bit and the irq
  freeze_hold_a: assert property (
    !ce |=> $stable(flags_v) && $stable(status_v) && $stable(irq))
    else $error("state moved while the clock enable was low");

  psp_c: cover property (ce && psp_access && psp_allowed ##1 flags_v[PP_BIT]);
  pwm_c: cover property (capcomp_a_mode == CCP_PWM && compare_a);
  irq_c: cover property ($rose(irq));
  clear_c: cover property (wr_a && !wval_flags[ADC_BIT] && flags_v[ADC_BIT]);
  freeze_c: cover property (!ce ##1 ce);

endmodule : periph_flag_bank

// ===== periph_flag_bank_tb.sv
// self-checking bench for the peripheral flag bank
`timescale 1ns/1ps
module periph_flag_bank_tb;
  import irq_flag_pkg::*;
  typedef struct packed {
    logic [4:0] sel;
    logic [1:0] mode;
    logic       sc;
    logic       ext;
    logic [7:0] a;
    logic [7:0] c;
  } row_s;
  logic              ref_clk, reset_n, ce, fire, sc, ext, irq;
  logic [4:0]        sel;
  logic [1:0]        mode, bresp, rresp, rs;
  logic [18:0]       ev;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rd;
  logic [3:0]        wstrb;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [7:0]        flags_a, flags_c;
  int                err_count, checks_done;
  // event index, ccp mode, single-chip, ext bus, flags a, flags c (cumulative)
  row_s rows [25] = '{
    '{5'd7,2'h0,1'b0,1'b0,8'h00,8'h00}, '{5'd7,2'h0,1'b1,1'b1,8'h00,8'h00},
    '{5'd7,2'h0,1'b1,1'b0,8'h80,8'h00}, '{5'd6,2'h0,1'b1,1'b0,8'hC0,8'h00},
    '{5'd5,2'h0,1'b1,1'b0,8'hE0,8'h00}, '{5'd4,2'h0,1'b1,1'b0,8'hF0,8'h00},
    '{5'd3,2'h0,1'b1,1'b0,8'hF8,8'h00}, '{5'd2,2'h2,1'b1,1'b0,8'hF8,8'h00},
    '{5'd14,2'h3,1'b1,1'b0,8'hF8,8'h00}, '{5'd2,2'h0,1'b1,1'b0,8'hF8,8'h00},
    '{5'd14,2'h1,1'b1,1'b0,8'hF8,8'h00}, '{5'd2,2'h3,1'b1,1'b0,8'hF8,8'h00},
    '{5'd14,2'h2,1'b1,1'b0,8'hFC,8'h00}, '{5'd1,2'h0,1'b1,1'b0,8'hFE,8'h00},
    '{5'd0,2'h0,1'b1,1'b0,8'hFF,8'h00}, '{5'd15,2'h0,1'b1,1'b0,8'hDF,8'h00},
    '{5'd16,2'h0,1'b1,1'b0,8'hCF,8'h00}, '{5'd8,2'h0,1'b1,1'b0,8'hCF,8'h01},
    '{5'd9,2'h0,1'b1,1'b0,8'hCF,8'h03}, '{5'd10,2'h0,1'b1,1'b0,8'hCF,8'h07},
    '{5'd11,2'h0,1'b1,1'b0,8'hCF,8'h0F}, '{5'd12,2'h0,1'b1,1'b0,8'hCF,8'h1F},
    '{5'd13,2'h0,1'b1,1'b0,8'hCF,8'h3F}, '{5'd17,2'h0,1'b1,1'b0,8'hCF,8'h1F},
    '{5'd18,2'h0,1'b1,1'b0,8'hCF,8'h0F}};

  //////////////////////////////////////////////////////////////////////////////
  periph_flag_bank periph_flag_bank_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .single_chip_mode(sc), .ext_bus_active(ext), .psp_access(ev[7]), .adc_done(ev[6]),
    .rx_a_loaded(ev[5]), .rx_a_read(ev[15]), .tx_a_empty(ev[4]), .tx_a_written(ev[16]),
    .sync_serial_done(ev[3]), .capcomp_a_mode(mode), .capture_a(ev[2]), .compare_a(ev[14]),
    .timer_b_match(ev[1]), .timer_a_overflow(ev[0]), .rx_b_loaded(ev[13]),
    .rx_b_read(ev[17]), .tx_b_empty(ev[12]), .tx_b_written(ev[18]), .timer_d_event(ev[11]),
    .capcomp_cde_event(ev[10:8]), .peripheral_request_flags_a(flags_a),
    .peripheral_request_flags_c(flags_c), .irq(irq));
  periph_events periph_events_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .fire(fire), .sel(sel), .ev(ev));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t ns: got 0x%h, expected 0x%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks made %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // the bus waits for the slave however long it takes, up to a bound
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    r = bresp;
    if (n == 40) begin
      chk(32'h0, 32'h1);
      finish_test();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n == 40) begin
      chk(32'h0, 32'h1);
      finish_test();
    end
  endtask : axi_rd

  // flags land one cycle after the strobe; four edges leave margin for irq too
  task automatic pulse(input row_s r);
    @(posedge ref_clk);
    fire <= 1'b1;
    sel  <= r.sel;
    mode <= r.mode;
    sc   <= r.sc;
    ext  <= r.ext;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : pulse

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, fire, sc, ext, awvalid, wvalid, bready, arvalid, rready} = 9'h000;
    {sel, mode, awaddr, araddr, wdata} = 'h0;
    ce = 1'b1;
    wstrb = 4'hF;
    err_count = 0;
    checks_done = 0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(32'(flags_a), 32'h0);
    chk(32'(flags_c), 32'h0);
    chk(32'(irq), 32'h0);
    axi_rd(IRQ_MASK_OFF, rd, rs);
    chk(rd, 32'h0);
    $display("test reset values done");
    foreach (rows[i]) begin
      pulse(rows[i]);
      chk(32'(flags_a), 32'(rows[i].a));
      chk(32'(flags_c), 32'(rows[i].c));
      chk(32'(irq), 32'h0);
    end
    $display("test event rows done");
    axi_rd(IRQ_STATUS_OFF, rd, rs);
    chk(rd, 32'h00003FFF);
    axi_wr(IRQ_STATUS_OFF, 32'h00003FFE, rs);
    axi_rd(IRQ_STATUS_OFF, rd, rs);
    chk(rd, 32'h00000001);
    axi_wr(IRQ_MASK_OFF, 32'h00000001, rs);
    chk(32'(rs), 32'(RESP_OKAY));
    repeat (3) @(posedge ref_clk);
    chk(32'(irq), 32'h1);
    axi_wr(IRQ_STATUS_OFF, 32'h00000001, rs);
    repeat (3) @(posedge ref_clk);
    chk(32'(irq), 32'h0);
    chk(32'(flags_a), 32'h000000CF);
    $display("test interrupt path done");
    axi_wr(FLAGS_A_OFF, 32'h00000000, rs);
    chk(32'(flags_a), 32'h0);
    axi_wr(FLAGS_A_OFF, 32'h000000FF, rs);
    axi_rd(FLAGS_A_OFF, rd, rs);
    chk(rd, 32'h000000CF);
    axi_wr(FLAGS_C_OFF, 32'h000000FF, rs);
    axi_rd(FLAGS_C_OFF, rd, rs);
    chk(rd, 32'h0000000F);
    axi_wr(FLAGS_A_OFF, 32'h00000000, rs);
    pulse('{5'd2, 2'h1, 1'b1, 1'b0, 8'h04, 8'h0F});
    chk(32'(flags_a), 32'h00000004);
    chk(32'(irq), 32'h0);
    pulse('{5'd0, 2'h1, 1'b1, 1'b0, 8'h05, 8'h0F});
    chk(32'(irq), 32'h1);
    $display("test software access done");
    axi_rd(8'h10, rd, rs);
    chk(rd, 32'h0);
    chk(32'(rs), 32'(RESP_DECERR));
    axi_wr(8'h10, 32'hFFFFFFFF, rs);
    chk(32'(rs), 32'(RESP_DECERR));
    chk(32'(flags_a), 32'h00000005);
    $display("test unmapped access done");
    // a conversion strobe that arrives while frozen is lost on purpose
    ce <= 1'b0;
    pulse('{5'd6, 2'h1, 1'b1, 1'b0, 8'h05, 8'h0F});
    chk(32'(flags_a), 32'h00000005);
    ce <= 1'b1;
    pulse('{5'd6, 2'h1, 1'b1, 1'b0, 8'h45, 8'h0F});
    chk(32'(flags_a), 32'h00000045);
    $display("test clock enable done");
    finish_test();
  end
endmodule : periph_flag_bank_tb

// ===== reg_if.sv
// register access carrier between the bus slave and the flag bank
`timescale 1ns/1ps
interface reg_if;
  import irq_flag_pkg::*;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              rd_err;

  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
               input  wr_err, rd_data, rd_err);
  modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface : reg_if
